// *** mqf_flags.sv ***
`timescale 1ns/1ps
module mqf_flags
    import mqf_pkg::*;
#(
    parameter int NQ = 8,
    parameter int DEPTH = 1024,
    parameter int OFS_W = $clog2(DEPTH + 1)
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire mqf_io_t io_mode,
    input wire logic packet_mode,
    input wire logic default_offset_select,
    input wire logic wr_en,
    input wire logic [$clog2(NQ)-1:0] wr_queue,
    input wire logic rd_en,
    input wire logic [$clog2(NQ)-1:0] rd_queue,
    input wire logic ofs_wr_en,
    input wire logic [$clog2(NQ)-1:0] ofs_queue,
    input wire logic [OFS_W-1:0] ofs_value,
    input wire logic flag_skew_window_one,
    input wire logic flag_skew_window_two,
    input wire logic flag_skew_window_three,
    input wire logic packet_skew_window,
    output logic data_available_n,
    output logic queue_full_n,
    output logic almost_full_n,
    output logic [NQ-1:0] almost_full_status_bus,
    output logic rd_ready
);
    localparam int QW = $clog2(NQ);
    localparam int CW = $clog2(MQF_U36 * (DEPTH + 1) + 1);
    localparam int FW = QW + MQF_UNITS_W;

    if (NQ < 2 || (NQ & (NQ - 1)) != 0 || DEPTH < MQF_DEF_OFS_HI || OFS_W < $clog2(DEPTH + 1)) begin : g_chk
        $error("mqf_flags: NQ must be a power of two and DEPTH at least the high default offset");
    end

    typedef logic [CW-1:0] mqf_cnt_t;

    // ------------------------------------------------------------
    // Boundary arithmetic
    // ------------------------------------------------------------
    // The extra word only exists when the read side holds a full word
    function automatic mqf_cnt_t lim_units(input logic shr, input mqf_io_t m);
        logic ext;
        ext = shr && (mqf_out_units(m) == MQF_U36);
        return CW'((DEPTH + int'(ext)) * int'(MQF_U36));
    endfunction : lim_units

    function automatic mqf_cnt_t af_units(input mqf_cnt_t lim, input logic [OFS_W-1:0] ofs);
        return lim - CW'(int'(ofs) * int'(MQF_U36));
    endfunction : af_units

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mqf_cnt_t occ_q [NQ];
    mqf_cnt_t occ_d [NQ];
    mqf_cnt_t rcnt_q [NQ];
    mqf_cnt_t rcnt_d [NQ];
    logic [OFS_W-1:0] ofs_q [NQ];
    logic [NQ-1:0] shared_q;
    logic [NQ-1:0] shared_d;
    logic [NQ-1:0] af_raw;
    logic [NQ-1:0] af_s1_q;
    logic [NQ-1:0] bus_q;
    logic init_q;
    logic [QW-1:0] wq_q;
    logic wv1_q;
    logic wl1_q;
    logic wv2_q;
    logic [QW-1:0] wq1_q;
    logic [QW-1:0] wq2_q;
    logic ov_n_q;
    logic full_n_q;
    logic af_n_q;
    logic [2:0] wu;
    logic [2:0] ru;
    logic [2:0] rtake;
    logic wr_room;
    logic wr_acc;
    logic rd_acc;
    logic ov_late;
    logic drain_fire;
    logic [QW-1:0] dq;
    logic [2:0] du;
    logic af_nxt;
    logic rd_inc_any;
    logic ret_held_q;
    logic af_hold;
    logic af_held_q;
    logic [NQ-1:0] bus_hold;
    logic [NQ-1:0] bus_held_q;

    assign wu = mqf_in_units(io_mode);
    assign ru = mqf_out_units(io_mode);
    assign ov_late = (io_mode == MQF_IO_36_36 && packet_mode) ? packet_skew_window : flag_skew_window_one;
    // Narrow inputs may leave a part word; the read takes what is there
    assign rtake = (rcnt_q[rd_queue] < mqf_cnt_t'(ru)) ? rcnt_q[rd_queue][2:0] : ru;
    assign wr_room = (occ_q[wr_queue] + mqf_cnt_t'(wu))
        <= lim_units((occ_q[wr_queue] == '0) ? (rd_queue == wr_queue) : shared_q[wr_queue], io_mode);
    assign wr_acc = ce & wr_en & wr_room & init_q;
    assign rd_acc = ce & rd_en & rd_ready & (rcnt_q[rd_queue] != '0);
    assign rd_inc_any = (wv1_q && !wl1_q && wq1_q == rd_queue) || (wv2_q && wq2_q == rd_queue);

    // ------------------------------------------------------------
    // Read-to-write return path
    // ------------------------------------------------------------
    mqf_stream_if #(.W(FW)) rd_fill ();
    mqf_stream_if #(.W(FW)) rd_drain ();

    assign rd_fill.valid = rd_acc;
    assign rd_fill.data = {rd_queue, rtake};
    // A late window holds the head back one cycle only, never longer
    assign rd_drain.ready = !flag_skew_window_one || ret_held_q;
    assign drain_fire = ce & rd_drain.valid & rd_drain.ready;
    assign dq = rd_drain.data[FW-1:MQF_UNITS_W];
    assign du = rd_drain.data[MQF_UNITS_W-1:0];
    assign rd_ready = rd_fill.ready;

    mqf_fifo #(.W(FW), .DEPTH(MQF_BUF_DEPTH)) u_ret (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .fill(rd_fill),
        .drain(rd_drain)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ret_held_q <= 1'b0;
        end else if (ce) begin
            ret_held_q <= rd_drain.valid && !rd_drain.ready;
        end
    end

    // ------------------------------------------------------------
    // Occupancy views
    // ------------------------------------------------------------
    always_comb begin
        for (int q = 0; q < NQ; q++) begin
            occ_d[q] = occ_q[q]
                + ((wr_acc && wr_queue == QW'(q)) ? mqf_cnt_t'(wu) : '0)
                - ((drain_fire && dq == QW'(q)) ? mqf_cnt_t'(du) : '0);
            shared_d[q] = (wr_acc && wr_queue == QW'(q) && occ_q[q] == '0) ? (rd_queue == QW'(q)) : shared_q[q];
            rcnt_d[q] = rcnt_q[q]
                + ((wv1_q && !wl1_q && wq1_q == QW'(q)) ? mqf_cnt_t'(wu) : '0)
                + ((wv2_q && wq2_q == QW'(q)) ? mqf_cnt_t'(wu) : '0)
                - ((rd_acc && rd_queue == QW'(q)) ? mqf_cnt_t'(rtake) : '0);
            af_raw[q] = occ_q[q] >= af_units(lim_units(shared_q[q], io_mode), ofs_q[q]);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int q = 0; q < NQ; q++) begin
                occ_q[q] <= '0;
                rcnt_q[q] <= '0;
            end
            shared_q <= '0;
        end else if (ce) begin
            for (int q = 0; q < NQ; q++) begin
                occ_q[q] <= occ_d[q];
                rcnt_q[q] <= rcnt_d[q];
            end
            shared_q <= shared_d;
        end
    end

    // Write notice reaches the read side one cycle later, two if late
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wv1_q <= 1'b0;
            wl1_q <= 1'b0;
            wq1_q <= '0;
            wv2_q <= 1'b0;
            wq2_q <= '0;
        end else if (ce) begin
            wv1_q <= wr_acc;
            wl1_q <= ov_late;
            wq1_q <= wr_queue;
            wv2_q <= wv1_q & wl1_q;
            wq2_q <= wq1_q;
        end
    end

    // ------------------------------------------------------------
    // Offsets
    // ------------------------------------------------------------
    // Strap is taken on the first enabled edge after reset release
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            init_q <= 1'b0;
            for (int q = 0; q < NQ; q++) begin
                ofs_q[q] <= OFS_W'(MQF_DEF_OFS_LO);
            end
        end else if (ce) begin
            if (!init_q) begin
                init_q <= 1'b1;
                for (int q = 0; q < NQ; q++) begin
                    ofs_q[q] <= default_offset_select ? OFS_W'(MQF_DEF_OFS_HI) : OFS_W'(MQF_DEF_OFS_LO);
                end
            end else if (ofs_wr_en && ofs_value <= OFS_W'(DEPTH)) begin
                ofs_q[ofs_queue] <= ofs_value;
            end
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ov_n_q <= 1'b1;
        end else if (ce) begin
            ov_n_q <= (rcnt_d[rd_queue] == '0);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            full_n_q <= 1'b1;
        end else if (ce) begin
            full_n_q <= (occ_d[wr_queue] + mqf_cnt_t'(wu))
                <= lim_units(shared_d[wr_queue], io_mode);
        end
    end

    // Two-stage status keeps the almost-full path off the counter adders
    assign af_nxt = !(af_s1_q[wq_q] & af_raw[wq_q]);
    // A late window delays a release by one cycle, even if held high
    assign af_hold = af_nxt && !af_n_q && flag_skew_window_two && !af_held_q;
    assign bus_hold = ~(af_s1_q & af_raw) & ~bus_q & {NQ{flag_skew_window_three}} & ~bus_held_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            af_s1_q <= '0;
            wq_q <= '0;
            af_n_q <= 1'b1;
            af_held_q <= 1'b0;
        end else if (ce) begin
            af_s1_q <= af_raw;
            wq_q <= wr_queue;
            af_held_q <= af_hold;
            if (!af_hold) begin
                af_n_q <= af_nxt;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_q <= '1;
            bus_held_q <= '0;
        end else if (ce) begin
            bus_held_q <= bus_hold;
            for (int q = 0; q < NQ; q++) begin
                if (!(bus_hold[q] || (wr_queue != wq_q))) begin
                    bus_q[q] <= !(af_s1_q[q] & af_raw[q]);
                end
            end
        end
    end

    assign data_available_n = ov_n_q;
    assign queue_full_n = full_n_q;
    assign almost_full_n = af_n_q;
    assign almost_full_status_bus = bus_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_first_write;
        ce && wr_acc && wr_queue == rd_queue && rcnt_q[wr_queue] == '0 && !rd_inc_any;
    endsequence

    property p_ov_assert;
        @(posedge mclk) disable iff (!arst_n)
        (s_first_write and !ov_late) ##1 (ce && $stable(rd_queue)) |=> !data_available_n;
    endproperty
    a_ov_assert: assert property (p_ov_assert) else $error("data available late after first write");

    property p_ov_late;
        @(posedge mclk) disable iff (!arst_n)
        (s_first_write and ov_late) ##1 (ce && $stable(rd_queue) && rcnt_q[rd_queue] == '0 && !rd_inc_any)
        |=> data_available_n;
    endproperty
    a_ov_late: assert property (p_ov_late) else $error("late skew did not add a cycle");

    property p_ov_empty;
        @(posedge mclk) disable iff (!arst_n)
        rd_acc && rcnt_q[rd_queue] <= mqf_cnt_t'(ru) && !rd_inc_any |=> data_available_n;
    endproperty
    a_ov_empty: assert property (p_ov_empty) else $error("data available stayed low after last read");

    property p_full_edge;
        @(posedge mclk) disable iff (!arst_n)
        wr_acc && !(drain_fire && dq == wr_queue)
        && occ_q[wr_queue] + mqf_cnt_t'(wu) + mqf_cnt_t'(wu) > lim_units(shared_d[wr_queue], io_mode)
        |=> !queue_full_n;
    endproperty
    a_full_edge: assert property (p_full_edge) else $error("full not asserted on filling write");

    property p_full_release;
        @(posedge mclk) disable iff (!arst_n)
        $rose(queue_full_n) && $past(wr_queue) == $past(wq_q) && !$past(flag_skew_window_one, 1)
        |-> $past(drain_fire);
    endproperty
    a_full_release: assert property (p_full_release) else $error("full released without a read");

    property p_af_assert;
        @(posedge mclk) disable iff (!arst_n)
        ce && $past(ce) && af_raw[wq_q] && $past(af_raw[wq_q]) && $stable(wq_q) |=> !almost_full_n;
    endproperty
    a_af_assert: assert property (p_af_assert) else $error("almost full not asserted two cycles on");

    property p_af_release;
        @(posedge mclk) disable iff (!arst_n)
        ce && !af_raw[wq_q] && !flag_skew_window_two |=> almost_full_n;
    endproperty
    a_af_release: assert property (p_af_release) else $error("almost full release late");

    property p_af_hold;
        @(posedge mclk) disable iff (!arst_n)
        ce && !almost_full_n && !af_raw[wq_q] && $past(af_raw[wq_q]) && $stable(wq_q) && flag_skew_window_two
        |=> !almost_full_n ##1 almost_full_n;
    endproperty
    a_af_hold: assert property (p_af_hold) else $error("late window did not add one cycle");

    property p_bus_assert;
        @(posedge mclk) disable iff (!arst_n)
        ce && af_raw[1] && af_s1_q[1] && wr_queue == wq_q |=> !almost_full_status_bus[1];
    endproperty
    a_bus_assert: assert property (p_bus_assert) else $error("status bus bit not asserted");

    property p_ofs_default;
        @(posedge mclk) disable iff (!arst_n)
        $rose(init_q) |-> ofs_q[0] == ($past(default_offset_select) ? OFS_W'(MQF_DEF_OFS_HI) : OFS_W'(MQF_DEF_OFS_LO));
    endproperty
    a_ofs_default: assert property (p_ofs_default) else $error("default offset wrong");

endmodule : mqf_flags

// *** mqf_pkg.sv ***
package mqf_pkg;

    // ------------------------------------------------------------
    // Bus-matching setups
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MQF_IO_36_36,
        MQF_IO_18_36,
        MQF_IO_9_36,
        MQF_IO_36_18,
        MQF_IO_36_9
    } mqf_io_t;

    // ------------------------------------------------------------
    // Widths, counts and reset values
    // ------------------------------------------------------------
    // Occupancy is kept in 9-bit units so every setup shares one counter
    localparam int MQF_UNITS_W = 3;
    localparam logic [2:0] MQF_U36 = 3'h4;
    localparam logic [2:0] MQF_U18 = 3'h2;
    localparam logic [2:0] MQF_U9 = 3'h1;
    localparam int MQF_DEF_OFS_LO = 8;
    localparam int MQF_DEF_OFS_HI = 128;
    localparam int MQF_BUF_DEPTH = 4;
    localparam int MQF_OV_ASSERT_CYC = 1;
    localparam int MQF_PAF_ASSERT_CYC = 2;

    function automatic logic [2:0] mqf_in_units(input mqf_io_t m);
        unique case (m)
            MQF_IO_18_36: return MQF_U18;
            MQF_IO_9_36: return MQF_U9;
            default: return MQF_U36;
        endcase
    endfunction : mqf_in_units

    function automatic logic [2:0] mqf_out_units(input mqf_io_t m);
        unique case (m)
            MQF_IO_36_18: return MQF_U18;
            MQF_IO_36_9: return MQF_U9;
            default: return MQF_U36;
        endcase
    endfunction : mqf_out_units

endpackage : mqf_pkg

// *** mqf_stream_if.sv ***
`timescale 1ns/1ps
interface mqf_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : mqf_stream_if

// *** mqf_fifo.sv ***
`timescale 1ns/1ps
module mqf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    mqf_stream_if.snk fill,
    mqf_stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Pointers wrap by overflow, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("mqf_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic rdy_q;
    logic push;
    logic pop;

    assign push = ce & fill.valid & rdy_q;
    assign pop = ce & drain.ready & (cnt_q != '0);
    assign fill.ready = rdy_q;
    assign drain.valid = (cnt_q != '0);
    assign drain.data = mem[rp_q];

    always_comb begin
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q] <= fill.data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else if (ce) begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            cnt_q <= cnt_d;
            // Registered ready; a stalled drain really fills the buffer
            rdy_q <= (cnt_d != CW'(DEPTH));
        end
    end

endmodule : mqf_fifo

// *** mqf_host_model.sv ***
`timescale 1ns/1ps
// --------
// Host on the write and read ports
// --------
// Requests change only at a rising edge; the bench decides when
module mqf_host_model #(
    parameter int QW = 2
) (
    output logic wr_en,
    output logic [QW-1:0] wr_queue,
    output logic rd_en,
    output logic [QW-1:0] rd_queue
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_queue = '0;
        rd_queue = '0;
    end

    task automatic req(input logic w, input logic r);
        wr_en <= w;
        rd_en <= r;
    endtask : req

    task automatic sel(input logic [QW-1:0] wq, input logic [QW-1:0] rq);
        wr_queue <= wq;
        rd_queue <= rq;
    endtask : sel
endmodule : mqf_host_model

// *** multiqueue_flag_boundaries_tb.sv ***
`timescale 1ns/1ps
module multiqueue_flag_boundaries_tb;
    import mqf_pkg::*;
    // --------
    // Bench state
    // --------
    localparam int D = 256;
    localparam int OW = $clog2(D + 1);
    logic mclk, arst_n, ce, packet_mode, default_offset_select, ofs_wr_en;
    mqf_io_t io_mode;
    logic [1:0] ofs_queue, wr_queue, rd_queue;
    logic [OW-1:0] ofs_value;
    logic sk1, sk2, sk3, skp, wr_en, rd_en, rd_ready, dav_n, full_n, af_n;
    logic [3:0] af_bus_n;
    logic pw, pr, prdy, pful, c1, c2, cmp_dav;
    logic [31:0] rs;
    int fail_count, samples_checked, occ, rc, lim, m, win, ou, nacc, d1, d2, q1, q2;
    int cycles = 0;
    int win_t[5] = '{4, 2, 1, 4, 4};
    int ou_t[5] = '{4, 4, 4, 2, 1};

    mqf_flags #(.NQ(4), .DEPTH(D)) mqf_flags_i (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .io_mode(io_mode), .packet_mode(packet_mode),
        .default_offset_select(default_offset_select), .wr_en(wr_en), .wr_queue(wr_queue),
        .rd_en(rd_en), .rd_queue(rd_queue), .ofs_wr_en(ofs_wr_en), .ofs_queue(ofs_queue),
        .ofs_value(ofs_value), .flag_skew_window_one(sk1), .flag_skew_window_two(sk2),
        .flag_skew_window_three(sk3), .packet_skew_window(skp), .data_available_n(dav_n),
        .queue_full_n(full_n), .almost_full_n(af_n), .almost_full_status_bus(af_bus_n),
        .rd_ready(rd_ready));

    mqf_host_model #(.QW(2)) mqf_host_model_i (
        .wr_en(wr_en), .wr_queue(wr_queue), .rd_en(rd_en), .rd_queue(rd_queue));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Well above the longest run of fills and drains
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            stop_test();
        end
    end

    // --------
    // Helpers
    // --------
    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t flag seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic set_ofs(input int v);
        ofs_wr_en <= 1'b1;
        ofs_value <= OW'(v);
        @(posedge mclk);
        ofs_wr_en <= 1'b0;
        @(posedge mclk);
    endtask : set_ofs

    // One cycle: request now, judge the previous request at the falling edge
    task automatic step(input logic w, input logic r);
        logic wt, rt, late, cn;
        int rr;
        mqf_host_model_i.req(w, r);
        @(negedge mclk);
        late = packet_mode ? skp : sk1;
        wt = pw && (occ + win <= lim);
        rt = pr && prdy && (rc > 0);
        rr = rt ? ((rc < ou) ? rc : ou) : 0;
        if (pw && pful) nacc++;
        if (wt && occ == 0) lim = (rd_queue == wr_queue && ou == 4) ? 4 * (D + 1) : 4 * D;
        rc = rc - rr + (late ? d2 : d1);
        d2 = d1;
        d1 = wt ? win : 0;
        // Write side sees a read one edge late, two when skewed
        occ = occ + (wt ? win : 0) - (sk1 ? q2 : q1);
        q2 = q1;
        q1 = rr;
        cn = (occ - (wt ? win : 0)) >= (lim - 4 * m);
        chk(full_n, (occ + win > lim) ? 1'b0 : 1'b1);
        chk(af_n, !(c1 || (sk2 && c2)));
        chk(af_bus_n[1], !(c1 || (sk3 && c2)));
        if (cmp_dav) chk(dav_n, rc == 0);
        c2 = c1;
        c1 = cn;
        pw = w;
        pr = r;
        prdy = rd_ready;
        pful = full_n;
        @(posedge mclk);
    endtask : step

    // --------
    // One run per setup and sharing
    // --------
    task automatic run(input int r);
        int md;
        logic sh, lt;
        md = r % 5;
        sh = (r < 5);
        lt = (r % 3 == 0);
        @(posedge mclk);
        arst_n <= 1'b0;
        default_offset_select <= r[0];
        io_mode <= mqf_io_t'(md);
        packet_mode <= (md == 0);
        sk1 <= lt;
        skp <= lt;
        sk2 <= 1'b0;
        sk3 <= 1'b0;
        mqf_host_model_i.sel(2'h1, sh ? 2'h1 : 2'h2);
        mqf_host_model_i.req(1'b0, 1'b0);
        {occ, rc, nacc, d1, d2, q1, q2} = '0;
        {pw, pr, prdy, c1, c2} = '0;
        pful = 1'b1;
        lim = 1 << 30;
        cmp_dav = sh;
        win = win_t[md];
        ou = ou_t[md];
        m = r[0] ? 128 : 8;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        if (r >= 2) begin
            rs = xs(rs);
            m = (r == 5) ? 0 : rs % (D - 1) + 1;
            set_ofs(m);
            if (r == 2) set_ofs(D + 1);
        end
        step(1'b1, 1'b0);
        repeat (4) step(1'b0, 1'b0);
        sk1 <= 1'b0;
        skp <= 1'b0;
        for (int i = 0; i < 8 * D + 16 && pful !== 1'b0; i++) begin
            rs = xs(rs);
            step(rs[1:0] != 2'h0, 1'b0);
        end
        chk(nacc, ((sh && ou == 4) ? D + 1 : D) * 4 / win);
        repeat (3) step(1'b1, 1'b0);
        // Release timing with skew windows one, two and three, from a full queue with zero offset
        if (r == 5) begin
            mqf_host_model_i.sel(2'h1, 2'h1);
            for (int k = 0; k < 3; k++) begin
                sk1 <= (k == 1);
                sk2 <= (k == 2);
                sk3 <= (k == 2);
                repeat (4) step(1'b0, 1'b0);
                cmp_dav = 1'b1;
                step(1'b0, 1'b1);
                repeat (5) step(1'b0, 1'b0);
                step(1'b1, 1'b0);
                repeat (3) step(1'b0, 1'b0);
            end
            sk1 <= 1'b0;
            sk2 <= 1'b0;
            sk3 <= 1'b0;
        end
        mqf_host_model_i.sel(2'h1, 2'h1);
        repeat (3) step(1'b0, 1'b0);
        cmp_dav = 1'b1;
        for (int i = 0; i < 8 * D && rc > 0; i++) begin
            rs = xs(rs);
            step(1'b0, rs[1:0] != 2'h0);
        end
        repeat (3) step(1'b0, 1'b0);
    endtask : run

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        packet_mode = 1'b0;
        default_offset_select = 1'b0;
        ofs_wr_en = 1'b0;
        ofs_queue = 2'h1;
        ofs_value = '0;
        io_mode = MQF_IO_36_36;
        {sk1, sk2, sk3, skp} = 4'h0;
        fail_count = 0;
        samples_checked = 0;
        rs = 32'h37;
        for (int r = 0; r < 10; r++) begin
            run(r);
        end
        stop_test();
    end
endmodule : multiqueue_flag_boundaries_tb
